// ==== dpsc_params.svh ====
// Constants of the disk positioner seek control: offsets, fields, counts.
// Assumes inclusion by bare name from the package, the synchroniser, the settle timer and the top module.
`ifndef DPSC_PARAMS_SVH
`define DPSC_PARAMS_SVH
// Notes on behaviour
// - Start done sets forward direction, first seek
// - First seek: set normal seek when area, zero low
// - Slow motion with normal seek reverses travel
// - Reverse pass at centre zero: forward, slow low
// - Subtract stored cylinder from new address
// - Positive difference forward, negative difference reverse
// - Load magnitude, decrement per track step
// - Flag difference equals one near target
// - Seek strobe: prepare, clear end, velocity mode
// - Seek strobe with normal seek enables counting
// - Decel flag high below 32 remaining
// - Speed reference: max, or low count bits
// - Final step: stop count, end position, servo
// - Derive track pulses, areas, one step per track
// - Speed in window: end position, slow, servo
// - Settle expiry: on cylinder, attention, clear slow motion
// - Address bit zero picks target, edge polarity
// - Servo select picks position or velocity path
// - Rezero strobe: slow motion, reverse, force decel
// - Track zero on rezero: forward, end reset
// - Master clear resets seek state and cylinder
// - Fault retracts arm, parks, reports unsafe
`define DPSC_CLK_MHZ      25
`define DPSC_SETTLE_US    1000
`define DPSC_SET_W        24
`define DPSC_NPIN         10
`define DPSC_CNT_W        9
`define DPSC_DECEL_LIMIT  9'h020
`define DPSC_CNT_ONE      9'h001
`define DPSC_SPEED_MAX    6'h3F
`define DPSC_OFS_CMD      8'h00
`define DPSC_OFS_CTRL     8'h04
`define DPSC_OFS_STAT     8'h08
`define DPSC_OFS_CNT      8'h0C
`define DPSC_CMD_SEEK_A   8
`define DPSC_CMD_SEEK_B   9
`define DPSC_CMD_REZERO   10
`define DPSC_CTRL_DECEL_X 0
`define DPSC_CTRL_MCLR    1
`define DPSC_CTRL_FCLR    2
`endif

// ==== dpsc_pkg.sv ====
// Types of the disk positioner seek control.
// Assumes dpsc_params.svh is reachable on the include path.
`include "dpsc_params.svh"
package dpsc_pkg;
  // ****************************************************************
  // Carriers
  // ****************************************************************
  typedef struct packed {
    logic quadrature_cos;
    logic quadrature_sin;
    logic optical_zero_flag;
    logic track_centre_flag;
    logic speed_in_window;
    logic mech_on_cyl_window;
    logic retract_switch;
    logic unsafe_fault;
    logic start_done;
    logic speed_error;
  } dpsc_pins_s;

  typedef struct packed {
    logic       direction_forward_ff;
    logic       position_servo_select;
    logic       servo_feedback;
    logic       amp_block;
    logic       target_odd;
    logic [5:0] speed_ref;
  } dpsc_drive_s;

  typedef struct packed {
    logic on_cylinder;
    logic alert_flag;
    logic fault_two_report;
    logic parked_position;
  } dpsc_iface_s;

  // ****************************************************************
  // Module state
  // ****************************************************************
  typedef struct packed {
    logic [`DPSC_NPIN-1:0] s1;
    logic [`DPSC_NPIN-1:0] s2;
    logic [`DPSC_NPIN-1:0] s3;
    logic [`DPSC_NPIN-1:0] q;
  } dpsc_sync_s;

  typedef struct packed {
    logic [`DPSC_SET_W-1:0] cnt;
    logic                   busy;
    logic                   trig_d;
    logic                   done;
  } dpsc_settle_s;

  typedef struct packed {
    dpsc_pins_s           pv;
    logic                 dir;
    logic                 ns;
    logic                 sm;
    logic                 slow;
    logic                 ep;
    logic                 ec;
    logic                 dforce;
    logic                 carriage_in_pack_ff;
    logic                 seen_opz;
    logic                 rz_done;
    logic                 rz_cmd;
    logic                 prep;
    logic                 parked;
    logic                 fault;
    logic                 tcclr;
    logic                 epol;
    logic                 sel_odd;
    logic                 tc;
    logic                 oncyl;
    logic                 alert;
    logic                 decel_x;
    logic                 soft_mc;
    logic                 ack;
    logic [`DPSC_CNT_W-1:0] cnt;
    logic [7:0]           cyl;
    logic [5:0]           spd;
    logic [31:0]          dat;
  } dpsc_st_s;

  function automatic logic dpsc_rise(input logic cur, input logic prev);
    return cur & ~prev;
  endfunction
endpackage

// ==== dpsc_sync.sv ====
// Three-stage input synchroniser for the drive pins.
// Assumes asynchronous pins; a change passes once stages two and three agree.
`timescale 1ns/1ns
`include "dpsc_params.svh"
module dpsc_sync
  import dpsc_pkg::*;
(
  input  wire logic                  clk,
  input  wire logic                  srst,
  input  wire logic [`DPSC_NPIN-1:0] din,
  output logic      [`DPSC_NPIN-1:0] dout
);
  import dpsc_pkg::*;
  dpsc_sync_s st_r;
  dpsc_sync_s st_nxt;

  always_comb begin
    st_nxt    = st_r;
    st_nxt.s1 = din;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    // Bitwise: keep old value where the two late stages still disagree
    st_nxt.q  = (st_r.s2 & st_r.s3) | (st_r.q & (st_r.s2 ^ st_r.s3));
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign dout = st_r.q;
endmodule

// ==== dpsc_settle.sv ====
// On-cylinder settle one-shot: times a level trigger, pulses on expiry.
// Assumes the trigger is synchronous; dropping it aborts the delay.
`timescale 1ns/1ns
`include "dpsc_params.svh"
module dpsc_settle
  import dpsc_pkg::*;
#(
  parameter int unsigned CYC = 25000
)(
  input  wire logic clk,
  input  wire logic srst,
  input  wire logic trig,
  output logic      done
);
  import dpsc_pkg::*;
  dpsc_settle_s st_r;
  dpsc_settle_s st_nxt;

  always_comb begin
    st_nxt        = st_r;
    st_nxt.done   = 1'b0;
    st_nxt.trig_d = trig;
    if (!trig) begin
      st_nxt.busy = 1'b0;
      st_nxt.cnt  = '0;
    end else if (!st_r.trig_d) begin
      st_nxt.busy = 1'b1;
      st_nxt.cnt  = `DPSC_SET_W'(CYC - 1);
    end else if (st_r.busy) begin
      if (st_r.cnt == '0) begin
        st_nxt.busy = 1'b0;
        st_nxt.done = 1'b1;
      end else begin
        st_nxt.cnt = st_r.cnt - `DPSC_SET_W'(1);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign done = st_r.done;
endmodule

// ==== dpsc_seek_ctrl.sv ====
// Head positioner seek sequencing with a classic Wishbone register slave.
// Assumes asynchronous drive pins and a single 25 MHz clock domain.
`timescale 1ns/1ns
`include "dpsc_params.svh"
module dpsc_seek_ctrl
  import dpsc_pkg::*;
#(
  parameter int unsigned SETTLE_US = `DPSC_SETTLE_US
)(
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  dpsc_pkg::dpsc_pins_s  pins,
  output dpsc_pkg::dpsc_drive_s drive,
  output dpsc_pkg::dpsc_iface_s iface
);
  import dpsc_pkg::*;

  localparam int unsigned SETTLE_CYC_RAW = SETTLE_US * `DPSC_CLK_MHZ;
  localparam int unsigned SETTLE_CYC =
    (SETTLE_CYC_RAW < 1) ? 1 : SETTLE_CYC_RAW;

  // ****************************************************************
  // Pin conditioning and settle timer
  // ****************************************************************
  logic [`DPSC_NPIN-1:0] sync_q;
  dpsc_pins_s            q;
  dpsc_st_s              st_r;
  dpsc_st_s              st_nxt;
  logic                  settle_done;

  dpsc_sync u_sync (
    .clk  (clk),
    .srst (srst),
    .din  (pins),
    .dout (sync_q)
  );

  assign q = dpsc_pins_s'(sync_q);

  dpsc_settle #(
    .CYC (SETTLE_CYC)
  ) u_settle (
    .clk  (clk),
    .srst (srst),
    .trig (st_r.ep & q.mech_on_cyl_window),
    .done (settle_done)
  );

  // ****************************************************************
  // Decoded conditions
  // ****************************************************************
  logic                   mc;
  logic                   area_even;
  logic                   track_zero_flag;
  logic                   return_zero_request;
  logic                   step;
  logic                   tc_nxt;
  logic                   diff_equals_one;
  logic                   decel;
  logic                   ps;
  logic                   req;
  logic                   wr;
  logic                   rd;
  logic                   cmd_wr;
  logic                   seek_cmd;
  logic                   rez_cmd;
  logic                   siw_rise;
  logic                   start_rise;
  logic [`DPSC_CNT_W-1:0] diff;
  logic [`DPSC_CNT_W-1:0] mag;
  logic                   diff_neg;
  logic [4:0]             cnt_lo;
  logic [31:0]            stat;

  always_comb begin
    mc        = st_r.fault | st_r.soft_mc;
    area_even = q.quadrature_cos;
    track_zero_flag       = q.optical_zero_flag & area_even;
    return_zero_request       = st_r.sm & st_r.ns;
    // Track flip-flop: cos rise sets, sin rise clears
    if (dpsc_rise(q.quadrature_cos, st_r.pv.quadrature_cos)) begin
      tc_nxt = 1'b1;
    end else if (dpsc_rise(q.quadrature_sin, st_r.pv.quadrature_sin)) begin
      tc_nxt = 1'b0;
    end else begin
      tc_nxt = st_r.tc;
    end
    step  = tc_nxt ^ st_r.tc;
    diff_equals_one   = st_r.ec & (st_r.cnt == `DPSC_CNT_ONE);
    decel = (st_r.ec & (st_r.cnt < `DPSC_DECEL_LIMIT)) | st_r.dforce;
    ps    = st_r.ep | st_r.parked;
    req   = wb_cyc_i & wb_stb_i & ~st_r.ack;
    wr    = req & wb_we_i;
    rd    = req & ~wb_we_i;
    cmd_wr   = wr & (wb_adr_i == `DPSC_OFS_CMD) & (&wb_sel_i[1:0]);
    seek_cmd = cmd_wr & (wb_dat_i[`DPSC_CMD_SEEK_A] |
                         wb_dat_i[`DPSC_CMD_SEEK_B]);
    rez_cmd  = cmd_wr & wb_dat_i[`DPSC_CMD_REZERO];
    siw_rise   = dpsc_rise(q.speed_in_window, st_r.pv.speed_in_window);
    start_rise = dpsc_rise(q.start_done, st_r.pv.start_done);
    diff     = {1'b0, wb_dat_i[7:0]} - {1'b0, st_r.cyl};
    diff_neg = diff[`DPSC_CNT_W-1];
    mag      = diff_neg ? (~diff + `DPSC_CNT_ONE) : diff;
    cnt_lo   = st_r.cnt[4:0];
    stat = {15'h0000, st_r.epol, st_r.tcclr, st_r.prep, st_r.carriage_in_pack_ff,
            st_r.fault, st_r.parked, ps, st_r.alert, st_r.oncyl, diff_equals_one,
            decel, st_r.ec, st_r.ep, st_r.slow, st_r.sm, st_r.ns,
            st_r.dir};
  end

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    st_nxt     = st_r;
    st_nxt.pv  = q;
    st_nxt.tc  = tc_nxt;
    st_nxt.ack = req;
    // Speed reference trails the counter by one cycle
    st_nxt.spd = decel ? {st_r.decel_x, cnt_lo} : `DPSC_SPEED_MAX;
    if (rd) begin
      case (wb_adr_i)
        `DPSC_OFS_CTRL: begin
          st_nxt.dat = {30'h00000000, st_r.soft_mc, st_r.decel_x};
        end
        `DPSC_OFS_STAT: begin
          st_nxt.dat = stat;
        end
        `DPSC_OFS_CNT: begin
          st_nxt.dat = {15'h0000, st_r.cnt, st_r.cyl};
        end
        default: begin
          st_nxt.dat = 32'h00000000;
        end
      endcase
    end
    if (wr && (wb_adr_i == `DPSC_OFS_CTRL) && wb_sel_i[0]) begin
      st_nxt.decel_x = wb_dat_i[`DPSC_CTRL_DECEL_X];
      st_nxt.soft_mc = wb_dat_i[`DPSC_CTRL_MCLR];
      if (wb_dat_i[`DPSC_CTRL_FCLR]) begin
        st_nxt.fault = 1'b0;
      end
    end
    if (start_rise) begin
      st_nxt.dir      = 1'b1;
      st_nxt.carriage_in_pack_ff      = 1'b1;
      st_nxt.seen_opz = 1'b0;
      st_nxt.parked   = 1'b0;
    end
    if (st_r.carriage_in_pack_ff && !st_r.ns) begin
      if (q.optical_zero_flag) begin
        st_nxt.seen_opz = 1'b1;
      end
      if (st_r.seen_opz && !area_even && !q.optical_zero_flag) begin
        st_nxt.ns = 1'b1;
      end
    end
    if (return_zero_request && !track_zero_flag && !st_r.rz_done) begin
      st_nxt.dir = 1'b0;
    end
    if (return_zero_request && track_zero_flag && !st_r.rz_done &&
        (q.track_centre_flag || st_r.rz_cmd)) begin
      st_nxt.dir     = 1'b1;
      st_nxt.slow    = 1'b0;
      st_nxt.rz_done = 1'b1;
      if (st_r.rz_cmd) begin
        st_nxt.ep = 1'b0;
      end
    end
    if (seek_cmd) begin
      st_nxt.prep    = 1'b1;
      st_nxt.ep      = 1'b0;
      st_nxt.oncyl   = 1'b0;
      st_nxt.alert   = 1'b0;
      st_nxt.sel_odd = wb_dat_i[0];
      st_nxt.epol    = ~wb_dat_i[0];
      if (st_r.ns) begin
        st_nxt.cyl = wb_dat_i[7:0];
        if (diff == '0) begin
          // Already there: skip velocity mode
          st_nxt.ep = 1'b1;
        end else begin
          st_nxt.dir = ~diff_neg;
          st_nxt.cnt = mag;
          st_nxt.ec  = 1'b1;
        end
      end
    end
    if (rez_cmd) begin
      st_nxt.sm      = 1'b1;
      st_nxt.rz_cmd  = 1'b1;
      st_nxt.rz_done = 1'b0;
      st_nxt.dforce  = ~st_r.ec;
      st_nxt.oncyl   = 1'b0;
      st_nxt.alert   = 1'b0;
    end
    if (st_r.ec && step) begin
      if (diff_equals_one) begin
        st_nxt.ec     = 1'b0;
        st_nxt.cnt    = '0;
        st_nxt.ep     = 1'b1;
        st_nxt.dforce = 1'b0;
      end else begin
        st_nxt.cnt = st_r.cnt - `DPSC_CNT_ONE;
      end
    end
    if (siw_rise) begin
      st_nxt.ep     = 1'b1;
      st_nxt.slow   = 1'b1;
      st_nxt.dforce = 1'b0;
    end
    if (settle_done) begin
      st_nxt.oncyl  = 1'b1;
      st_nxt.alert  = 1'b1;
      st_nxt.tcclr  = 1'b0;
      st_nxt.sm     = 1'b0;
      st_nxt.rz_cmd = 1'b0;
      st_nxt.prep   = 1'b0;
    end
    if (dpsc_rise(q.retract_switch, st_r.pv.retract_switch) && !st_r.dir) begin
      st_nxt.parked = 1'b1;
    end
    if (mc) begin
      st_nxt.carriage_in_pack_ff      = 1'b0;
      st_nxt.ns       = 1'b0;
      st_nxt.ep       = 1'b0;
      st_nxt.cyl      = 8'h00;
      st_nxt.dir      = 1'b0;
      st_nxt.sm       = 1'b1;
      st_nxt.slow     = 1'b1;
      st_nxt.ec       = 1'b0;
      st_nxt.dforce   = 1'b0;
      st_nxt.epol     = 1'b1;
      st_nxt.tcclr    = 1'b1;
      st_nxt.oncyl    = 1'b0;
      st_nxt.seen_opz = 1'b0;
      st_nxt.rz_done  = 1'b0;
    end
    // Fault set outranks a software clear in the same cycle
    if (q.unsafe_fault) begin
      st_nxt.fault = 1'b1;
      st_nxt.alert = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_r      <= '0;
      st_r.sm   <= 1'b1;
      st_r.slow <= 1'b1;
      st_r.epol <= 1'b1;
      st_r.tcclr <= 1'b1;
      st_r.spd  <= `DPSC_SPEED_MAX;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign wb_dat_o = st_r.dat;
  assign wb_ack_o = st_r.ack;
  assign drive.direction_forward_ff  = st_r.dir;
  assign drive.position_servo_select = ps;
  // Position path uses the sine, inverted unless positive edge chosen
  assign drive.servo_feedback = ps ? (q.quadrature_sin ^ ~st_r.epol)
                                   : q.speed_error;
  assign drive.amp_block  = st_r.parked;
  assign drive.target_odd = st_r.sel_odd;
  assign drive.speed_ref  = st_r.spd;
  assign iface.on_cylinder      = st_r.oncyl;
  assign iface.alert_flag       = st_r.alert;
  assign iface.fault_two_report = st_r.fault;
  assign iface.parked_position  = st_r.parked;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  property p_start_fwd;
    start_rise && !mc |=> st_r.dir && st_r.carriage_in_pack_ff;
  endproperty
  a_start_fwd: assert property (p_start_fwd) else $error("no fwd");

  property p_ns_set;
    st_r.carriage_in_pack_ff && !st_r.ns && st_r.seen_opz && !area_even &&
    !q.optical_zero_flag && !mc |=> st_r.ns;
  endproperty
  a_ns_set: assert property (p_ns_set) else $error("ns missing");

  property p_rev;
    return_zero_request && !track_zero_flag && !st_r.rz_done && !cmd_wr && !start_rise |=> !st_r.dir;
  endproperty
  a_rev: assert property (p_rev) else $error("no reverse");

  property p_seek_load;
    seek_cmd && st_r.ns && (diff != '0) && !mc
      |=> st_r.ec && (st_r.dir == !$past(diff_neg)) && !st_r.oncyl;
  endproperty
  a_seek_load: assert property (p_seek_load) else $error("load bad");

  property p_dec;
    st_r.ec && step && !diff_equals_one && !mc && !cmd_wr
      |=> st_r.cnt == $past(st_r.cnt) - `DPSC_CNT_ONE;
  endproperty
  a_dec: assert property (p_dec) else $error("no decrement");

  property p_decel_thr;
    st_r.ec && (st_r.cnt == `DPSC_DECEL_LIMIT) && step && !st_r.dforce &&
    !mc && !cmd_wr |-> !decel ##1 decel;
  endproperty
  a_decel_thr: assert property (p_decel_thr) else $error("decel");

  property p_spd;
    decel |=> st_r.spd == {$past(st_r.decel_x), $past(cnt_lo)};
  endproperty
  a_spd: assert property (p_spd) else $error("speed ref");

  property p_final;
    diff_equals_one && step && !mc && !cmd_wr |=> !st_r.ec && ps && !decel;
  endproperty
  a_final: assert property (p_final) else $error("final step");

  property p_siw;
    siw_rise && !mc && !cmd_wr |=> st_r.ep && st_r.slow && ps;
  endproperty
  a_siw: assert property (p_siw) else $error("window");

  property p_settle;
    settle_done && !mc && !cmd_wr |=> st_r.oncyl && st_r.alert && !st_r.sm;
  endproperty
  a_settle: assert property (p_settle) else $error("settle");

  property p_mclr;
    mc |=> !st_r.ns && !st_r.ep && (st_r.cyl == 8'h00) && !st_r.dir;
  endproperty
  a_mclr: assert property (p_mclr) else $error("master clear");
endmodule

// ==== dpsc_cu_model.sv ====
// Control unit model: a classic Wishbone master issuing single words.
// Assumes one request per go pulse, and go only while done is idle.
`timescale 1ns/1ns
module dpsc_cu_model (
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        go,
  input  wire logic        we,
  input  wire logic [7:0]  adr,
  input  wire logic [31:0] dat,
  output logic             wb_cyc_o,
  output logic             wb_stb_o,
  output logic             wb_we_o,
  output logic [7:0]       wb_adr_o,
  output logic [3:0]       wb_sel_o,
  output logic [31:0]      wb_dat_o,
  input  wire logic        wb_ack_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      rdat,
  output logic             done
);
  // ****************************************************************
  // Request holder
  // ****************************************************************
  // Address, command lines and strobe rise together and stay put until ack
  assign wb_stb_o = wb_cyc_o;
  always_ff @(posedge clk) begin
    done <= 1'b0;
    if (srst) begin
      wb_cyc_o <= 1'b0;
      wb_we_o  <= 1'b0;
      wb_adr_o <= 8'h00;
      wb_sel_o <= 4'h0;
      wb_dat_o <= 32'h0;
      rdat     <= 32'h0;
    end else if (wb_cyc_o && wb_ack_i) begin
      wb_cyc_o <= 1'b0;
      rdat     <= wb_dat_i;
      done     <= 1'b1;
    end else if (!wb_cyc_o && go) begin
      wb_cyc_o <= 1'b1;
      wb_we_o  <= we;
      wb_adr_o <= adr;
      wb_sel_o <= 4'hF;
      wb_dat_o <= dat;
    end
  end
endmodule

// ==== dpsc_seek_ctrl_tb.sv ====
// Self-checking bench for the seek controller.
// Assumes the control unit model as bus master; pins driven here.
`timescale 1ns/1ns
module dpsc_seek_ctrl_tb;
  import dpsc_pkg::*;
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic        go = 1'b0;
  logic        m_we = 1'b0;
  logic [7:0]  m_adr = 8'h00;
  logic [31:0] m_dat = 32'h0;
  logic        cyc, stb, we, ack, done;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] wdat, rdat_o, rdat, rd;
  dpsc_pins_s  pins = '0;
  dpsc_pins_s  p = '0;
  dpsc_drive_s drive;
  dpsc_iface_s iface;
  int          fail_count = 0;
  int          checked = 0;
  int          cyc_n = 0;
  bit          tc_st = 1'b0;
  always #20 clk = ~clk;
  dpsc_cu_model u_cu (.clk(clk), .srst(srst), .go(go), .we(m_we),
    .adr(m_adr), .dat(m_dat), .wb_cyc_o(cyc), .wb_stb_o(stb),
    .wb_we_o(we), .wb_adr_o(adr), .wb_sel_o(sel), .wb_dat_o(wdat),
    .wb_ack_i(ack), .wb_dat_i(rdat_o), .rdat(rdat), .done(done));
  dpsc_seek_ctrl #(.SETTLE_US(1)) u_dut (.clk(clk), .srst(srst),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat_o), .wb_ack_o(ack),
    .pins(pins), .drive(drive), .iface(iface));
  // ****************************************************************
  // Helpers
  // ****************************************************************
  task automatic summarize();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 20000) begin
      fail_count = fail_count + 1;
      summarize();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Ends at a falling edge so registered outputs have settled
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    go <= 1'b1;
    m_we <= w;
    m_adr <= a;
    m_dat <= d;
    @(posedge clk);
    go <= 1'b0;
    // Ends when done comes; the bench timeout ends it if done never does
    do begin
      @(negedge clk);
    end while (done !== 1'b1);
    chk(ack, 32'h0);
    rd = rdat;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] m,
                     input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(rd & m, e);
  endtask
  // Pins pass a three-stage synchroniser, so allow eight clocks
  task automatic apply();
    @(posedge clk);
    pins <= p;
    repeat (8) @(posedge clk);
    @(negedge clk);
  endtask
  // One track: cos rise sets the track flip-flop, sin rise clears it
  task automatic step();
    if (tc_st) p.quadrature_sin = 1'b1;
    else p.quadrature_cos = 1'b1;
    apply();
    p.quadrature_sin = 1'b0;
    p.quadrature_cos = 1'b0;
    apply();
    tc_st = ~tc_st;
  endtask
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset();
    chk({drive.direction_forward_ff, drive.speed_ref}, 32'h3F);
    chk(iface, 32'h0);
    rdc(8'h08, 32'h1800D, 32'h1800C);
    bus(1'b1, 8'h10, 32'hFFFF);
    rdc(8'h10, 32'hFFFFFFFF, 32'h0);
  endtask
  task automatic t_first();
    p.start_done = 1'b1;
    apply();
    chk(drive.direction_forward_ff, 32'h1);
    p.optical_zero_flag = 1'b1;
    p.quadrature_cos = 1'b1;
    apply();
    tc_st = 1'b1;
    p.quadrature_cos = 1'b0;
    apply();
    p.optical_zero_flag = 1'b0;
    apply();
    rdc(8'h08, 32'h3, 32'h2);
    p.optical_zero_flag = 1'b1;
    p.quadrature_cos = 1'b1;
    p.track_centre_flag = 1'b1;
    apply();
    rdc(8'h08, 32'hB, 32'h3);
    p.optical_zero_flag = 1'b0;
    p.quadrature_cos = 1'b0;
    p.track_centre_flag = 1'b0;
    apply();
  endtask
  task automatic t_bounds();
    logic [7:0] a [3] = '{8'h40, 8'h20, 8'h01};
    logic [8:0] d [3] = '{9'h040, 9'h020, 9'h01F};
    logic [6:0] s [3] = '{7'h21, 7'h20, 7'h60};
    logic [5:0] r [3] = '{6'h3F, 6'h3F, 6'h1F};
    for (int i = 0; i < 3; i++) begin
      bus(1'b1, 8'h00, {23'h0, 1'b1, a[i]});
      rdc(8'h0C, 32'h1FFFF, {15'h0, d[i], a[i]});
      rdc(8'h08, 32'h71, {25'h0, s[i]});
      chk({drive.position_servo_select, drive.speed_ref}, r[i]);
    end
    bus(1'b1, 8'h04, 32'h1);
    chk(drive.speed_ref, 32'h3F);
    bus(1'b1, 8'h04, 32'h0);
    p.speed_error = 1'b1;
    apply();
    chk(drive.servo_feedback, 32'h1);
    p.speed_error = 1'b0;
    apply();
    chk(drive.servo_feedback, 32'h0);
  endtask
  task automatic t_seek();
    bus(1'b1, 8'h00, 32'h205);
    rdc(8'h08, 32'h31, 32'h21);
    repeat (3) step();
    rdc(8'h08, 32'hB0, 32'hA0);
    rdc(8'h0C, 32'h1FF00, 32'h100);
    step();
    rdc(8'h08, 32'hF0, 32'h10);
    chk({drive.position_servo_select, drive.target_odd}, 32'h3);
    chk(drive.servo_feedback, 32'h1);
    p.mech_on_cyl_window = 1'b1;
    apply();
    chk(iface.on_cylinder, 32'h0);
    repeat (30) @(negedge clk);
    chk({iface.on_cylinder, iface.alert_flag}, 32'h3);
    rdc(8'h08, 32'h304, 32'h300);
    // Seek of 33 tracks crosses the deceleration threshold
    bus(1'b1, 8'h00, 32'h126);
    step();
    rdc(8'h08, 32'h40, 32'h0);
    step();
    rdc(8'h08, 32'h40, 32'h40);
    repeat (31) step();
    rdc(8'h08, 32'h30, 32'h10);
    repeat (30) @(negedge clk);
    chk(iface.on_cylinder, 32'h1);
  endtask
  task automatic t_rezero();
    bus(1'b1, 8'h00, 32'h400);
    rdc(8'h08, 32'h145, 32'h44);
    p.optical_zero_flag = 1'b1;
    p.quadrature_cos = 1'b1;
    apply();
    rdc(8'h08, 32'h19, 32'h1);
    p.speed_in_window = 1'b1;
    apply();
    rdc(8'h08, 32'h418, 32'h418);
    p = '0;
    apply();
  endtask
  task automatic t_fault();
    p.unsafe_fault = 1'b1;
    apply();
    chk({iface.fault_two_report, iface.alert_flag,
         drive.direction_forward_ff}, 32'h6);
    rdc(8'h08, 32'h2012, 32'h0);
    rdc(8'h0C, 32'hFF, 32'h0);
    p.retract_switch = 1'b1;
    apply();
    chk({iface.parked_position, drive.position_servo_select,
         drive.amp_block}, 32'h7);
    p.unsafe_fault = 1'b0;
    apply();
    bus(1'b1, 8'h04, 32'h4);
    rdc(8'h08, 32'h1000, 32'h0);
    // Software master clear undoes a fresh start
    p.start_done = 1'b1;
    apply();
    rdc(8'h08, 32'h2001, 32'h2001);
    bus(1'b1, 8'h04, 32'h2);
    rdc(8'h08, 32'h2011, 32'h0);
    bus(1'b1, 8'h04, 32'h0);
  endtask
  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    @(negedge clk);
    t_reset();
    t_first();
    t_bounds();
    t_seek();
    t_rezero();
    t_fault();
    summarize();
  end
endmodule
